//--- pkg/irq_prio_pkg.sv
// Register map, field positions and group codes of the interrupt prioritizer
package irq_prio_pkg;

  // Register addresses in the control register file
  localparam logic [7:0] PRIO_ADDR    = 8'hf9;
  localparam logic [7:0] PEND_ADDR    = 8'hfa;
  localparam logic [7:0] MASK_ADDR    = 8'hfb;

  // Field positions and widths
  localparam int         NUM_LEVELS   = 6;
  localparam int         MASTER_BIT   = 7;
  localparam int         C_MEMBER_BIT = 1;
  localparam int         B_MEMBER_BIT = 2;
  localparam int         A_MEMBER_BIT = 5;
  localparam int         ORD_BIT0     = 0;
  localparam int         ORD_BIT1     = 3;
  localparam int         ORD_BIT2     = 4;

  // Reset values of the defined parts
  localparam logic [5:0] PEND_RESET   = 6'h00;
  localparam logic [5:0] EN_RESET     = 6'h00;
  localparam logic [7:0] PRIO_RESET   = 8'h00;

  // Group order codes (bits 4,3,0)
  localparam logic [2:0] ORD_CAB      = 3'h1;
  localparam logic [2:0] ORD_ABC      = 3'h2;
  localparam logic [2:0] ORD_ACB      = 3'h3;
  localparam logic [2:0] ORD_BCA      = 3'h4;
  localparam logic [2:0] ORD_CBA      = 3'h5;
  localparam logic [2:0] ORD_BAC      = 3'h6;

  // Interrupt machine cycle sequencer states
  typedef enum logic [1:0] {IDLE_S, GRANT_S, SERVICE_S} ack_state_t;

endpackage

//--- hw/prio_pick.sv
// Six-level fixed-structure priority resolver for one programmed order
`timescale 1ns/1ps
module prio_pick
  import irq_prio_pkg::*;
(
  // Inputs
  input  wire logic [5:0] active,
  input  wire logic [7:0] prio,
  // Result
  output logic            any,
  output logic [2:0]      level
);

  logic [2:0] hi_a, lo_a, hi_b, lo_b, hi_c, lo_c;
  logic [2:0] ord;
  logic [2:0] seq [0:5];

  // Member order inside each group
  always_comb begin
    hi_a = prio[A_MEMBER_BIT] ? 3'h3 : 3'h5; // see R2
    lo_a = prio[A_MEMBER_BIT] ? 3'h5 : 3'h3; // see R1
    hi_b = prio[B_MEMBER_BIT] ? 3'h0 : 3'h2; // see R2
    lo_b = prio[B_MEMBER_BIT] ? 3'h2 : 3'h0;
    hi_c = prio[C_MEMBER_BIT] ? 3'h4 : 3'h1; // see R2
    lo_c = prio[C_MEMBER_BIT] ? 3'h1 : 3'h4;
  end

  // Group order, top two bits ignored
  assign ord = {prio[ORD_BIT2], prio[ORD_BIT1], prio[ORD_BIT0]}; // see R4

  always_comb begin
    seq[0] = hi_a; seq[1] = lo_a; seq[2] = hi_b;
    seq[3] = lo_b; seq[4] = hi_c; seq[5] = lo_c;
    unique case (ord) // see R3
      ORD_CAB: begin
        seq[0] = hi_c; seq[1] = lo_c; seq[2] = hi_a;
        seq[3] = lo_a; seq[4] = hi_b; seq[5] = lo_b;
      end
      ORD_ACB: begin
        seq[0] = hi_a; seq[1] = lo_a; seq[2] = hi_c;
        seq[3] = lo_c; seq[4] = hi_b; seq[5] = lo_b;
      end
      ORD_BCA: begin
        seq[0] = hi_b; seq[1] = lo_b; seq[2] = hi_c;
        seq[3] = lo_c; seq[4] = hi_a; seq[5] = lo_a;
      end
      ORD_CBA: begin
        seq[0] = hi_c; seq[1] = lo_c; seq[2] = hi_b;
        seq[3] = lo_b; seq[4] = hi_a; seq[5] = lo_a;
      end
      ORD_BAC: begin
        seq[0] = hi_b; seq[1] = lo_b; seq[2] = hi_a;
        seq[3] = lo_a; seq[4] = hi_c; seq[5] = lo_c;
      end
      default: begin
        // ABC, and unused codes fall back to it
      end
    endcase
  end

  // Highest ranked active level wins
  always_comb begin
    any   = 1'b0;
    level = 3'h0;
    for (int i = NUM_LEVELS - 1; i >= 0; i--) begin
      if (active[seq[i]]) begin
        any   = 1'b1;
        level = seq[i]; // see R5
      end
    end
  end

endmodule

//--- hw/irq_prioritizer.sv
// Vectored interrupt prioritizer with pending, mask and priority registers
//
// Overview of operation
// R1 - Six levels sorted into groups A, B, C
// R2 - Bits 1, 2, 5 order members
// R3 - Bits 4, 3, 0 order the groups
// R4 - Priority top bits ignored; register write-only
// R5 - Only the highest ranked pending request granted
// R6 - Request sets matching pending bit
// R7 - Pending register readable and writable
// R8 - Pending bits 6, 7 have no function
// R9 - Mask bits 0-5 enable levels
// R10 - Master enable bit 7 gates all levels
// R11 - Enable and disable instructions drive master
// R12 - Acknowledge clears master; return sets it
// R13 - Software disables before changing mask, priority
// R14 - Reset clears master and pending bits
// R15 - Acknowledge clears pending, hands vector level
// R16 - Software programs priority before enabling
`timescale 1ns/1ps
module irq_prioritizer
  import irq_prio_pkg::*;
(
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  // Request sources
  input  wire logic [5:0] LEVEL_REQUEST,
  // Register file access from the core
  input  wire logic [7:0] REG_ADDR,
  input  wire logic       REG_WRITE,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_READ,
  output logic [7:0]      REG_RDATA,
  // Core instructions
  input  wire logic       ENABLE_INSTR,
  input  wire logic       DISABLE_INSTR,
  input  wire logic       RETURN_INSTR,
  // Interrupt machine cycle handshake
  output logic            INT_REQUEST,
  input  wire logic       INT_ACK,
  output logic [2:0]      VECTOR_LEVEL,
  output logic            VECTOR_VALID
);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [5:0]  pend_q;
  logic [5:0]  en_q;
  logic        master_q;
  logic [7:0]  prio_q;
  logic [2:0]  vec_q;
  logic        vec_valid_q;
  logic [7:0]  rdata_q;
  ack_state_t  state_q;

  logic        win_any;
  logic [2:0]  win_level;
  logic        take;
  logic [5:0]  ack_clr;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // ---------------------------------------------------------------------------
  // Resolution
  // ---------------------------------------------------------------------------
  prio_pick u_pick (
    .active (pend_q & en_q),
    .prio   (prio_q),
    .any    (win_any),
    .level  (win_level)
  );

  // Request only while the master enable is set
  assign INT_REQUEST = master_q && win_any && (state_q == IDLE_S); // see R10
  assign take        = INT_REQUEST && INT_ACK;
  assign ack_clr     = take ? (6'h01 << win_level) : 6'h00;

  // Priority register, write-only, top bits dropped
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      prio_q <= PRIO_RESET;
    end else if (REG_WRITE && hit(REG_ADDR, PRIO_ADDR)) begin
      prio_q <= {2'b00, REG_WDATA[5:0]}; // see R4
    end
  end

  // Pending register: sources set, software writes, acknowledge clears
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      pend_q <= PEND_RESET; // see R14
    end else if (REG_WRITE && hit(REG_ADDR, PEND_ADDR)) begin
      pend_q <= REG_WDATA[5:0] | LEVEL_REQUEST; // see R7
    end else begin
      pend_q <= (pend_q & ~ack_clr) | LEVEL_REQUEST; // see R6
    end
  end

  // Individual enables
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      en_q <= EN_RESET;
    end else if (REG_WRITE && hit(REG_ADDR, MASK_ADDR)) begin
      en_q <= REG_WDATA[5:0]; // see R9
    end
  end

  // Master enable: reset, instructions, acknowledge and return
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      master_q <= 1'b0; // see R14
    end else if (take) begin
      master_q <= 1'b0; // see R12
    end else if (DISABLE_INSTR) begin
      master_q <= 1'b0; // see R11
    end else if (ENABLE_INSTR || RETURN_INSTR) begin
      master_q <= 1'b1; // see R11
    end else if (REG_WRITE && hit(REG_ADDR, MASK_ADDR)) begin
      master_q <= REG_WDATA[MASTER_BIT]; // see R10
    end
  end

  // Interrupt machine cycle sequencer
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_q <= IDLE_S;
    end else begin
      unique case (state_q)
        IDLE_S:    if (take) state_q <= GRANT_S;
        GRANT_S:   state_q <= SERVICE_S;
        SERVICE_S: if (RETURN_INSTR) state_q <= IDLE_S;
        default:   state_q <= IDLE_S;
      endcase
    end
  end

  // Vector selection handed to the core
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      vec_q       <= 3'h0;
      vec_valid_q <= 1'b0;
    end else begin
      vec_valid_q <= take;
      if (take) begin
        vec_q <= win_level; // see R15
      end
    end
  end

  // Read data; priority reads as zero, unused pending bits read zero
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      rdata_q <= 8'h00;
    end else if (REG_READ) begin
      if (hit(REG_ADDR, PEND_ADDR)) begin
        rdata_q <= {2'b00, pend_q}; // see R8
      end else if (hit(REG_ADDR, MASK_ADDR)) begin
        rdata_q <= {master_q, 1'b0, en_q};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  assign REG_RDATA    = rdata_q;
  assign VECTOR_LEVEL = vec_q;
  assign VECTOR_VALID = vec_valid_q;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  master_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R12
    take |=> !master_q)
    else $error("master enable not cleared by acknowledge");

  no_req_off_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R10
    !master_q |-> !INT_REQUEST)
    else $error("request while master disabled");

  pend_set_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R6
    LEVEL_REQUEST[0] |=> pend_q[0])
    else $error("request did not set pending bit");

  vec_level_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R15
    take |=> VECTOR_VALID && VECTOR_LEVEL == $past(win_level))
    else $error("vector level wrong");

  win_enabled_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R5
    INT_REQUEST |-> pend_q[win_level] && en_q[win_level])
    else $error("winner not pending and enabled");

  ack_clear_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R15
    take && !LEVEL_REQUEST[win_level] && !REG_WRITE |=> !pend_q[$past(win_level)])
    else $error("pending bit not cleared on acknowledge");

  ei_set_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R11
    ENABLE_INSTR && !DISABLE_INSTR && !take |=> master_q)
    else $error("enable instruction ignored");

  di_clr_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R11
    DISABLE_INSTR |=> !master_q)
    else $error("disable instruction ignored");

  prio_top_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R4
    prio_q[7:6] == 2'b00)
    else $error("priority top bits stored");

  reset_clr_a: assert property (@(posedge SYS_CLK) // see R14
    RESET |=> !master_q && (pend_q == PEND_RESET))
    else $error("reset did not clear state");

  ret_set_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R12
    RETURN_INSTR && !DISABLE_INSTR && !take |=> master_q)
    else $error("return instruction did not set master enable");

  req_drop_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R15
    take |=> !INT_REQUEST)
    else $error("request still raised after acknowledge");

  pend_wr_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R7
    REG_WRITE && hit(REG_ADDR, PEND_ADDR)
    |=> pend_q == ($past(REG_WDATA[5:0]) | $past(LEVEL_REQUEST)))
    else $error("pending write not loaded");

  en_wr_a: assert property (@(posedge SYS_CLK) disable iff (RESET) // see R9
    REG_WRITE && hit(REG_ADDR, MASK_ADDR) |=> en_q == $past(REG_WDATA[5:0]))
    else $error("mask write did not load enables");

endmodule

//--- verification/core_model.sv
// Core model: takes interrupt requests and returns from service after a delay
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input  wire logic       SYS_CLK,
  input  wire logic       RESET,
  // Device side
  input  wire logic       INT_REQUEST,
  input  wire logic       VECTOR_VALID,
  output logic            INT_ACK,
  output logic            RETURN_INSTR,
  // Response delays
  input  wire logic [3:0] ack_dly,
  input  wire logic [3:0] ret_dly
);
  logic [3:0] cnt_q;
  logic       busy_q;

  // Ack pulsed for one cycle once cnt_q reaches ack_dly; return pulsed ret_dly after vector
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      {INT_ACK, RETURN_INSTR, busy_q, cnt_q} <= '0;
    end else begin
      RETURN_INSTR <= 1'b0;
      cnt_q        <= cnt_q + 4'h1;
      if (VECTOR_VALID) begin
        busy_q <= 1'b1;
        cnt_q  <= 4'h0;
      end else if (busy_q) begin
        if (cnt_q == ret_dly) begin
          RETURN_INSTR <= 1'b1;
          busy_q       <= 1'b0;
        end
      end else if (!INT_REQUEST || INT_ACK) begin
        INT_ACK <= 1'b0;
        cnt_q   <= 4'h0;
      end else if (cnt_q >= ack_dly) begin
        INT_ACK <= 1'b1;
      end
    end
  end
endmodule

//--- verification/vectored_interrupt_prioritizer_tb.sv
// Self-checking bench for the vectored interrupt prioritizer
`timescale 1ns/1ps
module vectored_interrupt_prioritizer_tb;
  import irq_prio_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, ei = 1'b0, di = 1'b0;
  logic        irq, ack, ret, vv;
  logic [5:0]  lreq = 6'h00;
  logic [7:0]  addr = 8'h00, wd = 8'h00, rdat, got, p, m, q, e;
  logic [2:0]  vl, c;
  logic [3:0]  ad = 4'h0, rdl = 4'h4;
  logic [31:0] rnd = 32'h68a7;
  int          bad_count = 0, total_checks = 0, n;

  // Clock at 4 ns
  always #2 clk = ~clk;

  irq_prioritizer DUT (.SYS_CLK(clk), .RESET(rst), .LEVEL_REQUEST(lreq), .REG_ADDR(addr),
    .REG_WRITE(wr), .REG_WDATA(wd), .REG_READ(rd), .REG_RDATA(rdat), .ENABLE_INSTR(ei),
    .DISABLE_INSTR(di), .RETURN_INSTR(ret), .INT_REQUEST(irq), .INT_ACK(ack),
    .VECTOR_LEVEL(vl), .VECTOR_VALID(vv));
  core_model core (.SYS_CLK(clk), .RESET(rst), .INT_REQUEST(irq), .VECTOR_VALID(vv),
    .INT_ACK(ack), .RETURN_INSTR(ret), .ack_dly(ad), .ret_dly(rdl));

  // Random source
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected winner: group order from bits 4,3,0, members from bits 5,2,1
  function automatic logic [2:0] win(input logic [7:0] pr, input logic [5:0] a);
    logic [2:0] hi [3];
    logic [2:0] lo [3];
    logic [5:0] go;
    hi[0] = pr[5] ? 3'h3 : 3'h5;
    lo[0] = pr[5] ? 3'h5 : 3'h3;
    hi[1] = pr[2] ? 3'h0 : 3'h2;
    lo[1] = pr[2] ? 3'h2 : 3'h0;
    hi[2] = pr[1] ? 3'h4 : 3'h1;
    lo[2] = pr[1] ? 3'h1 : 3'h4;
    case ({pr[4], pr[3], pr[0]})
      3'h1: go = 6'h21;
      3'h3: go = 6'h09;
      3'h4: go = 6'h18;
      3'h5: go = 6'h24;
      3'h6: go = 6'h12;
      default: go = 6'h06;
    endcase
    for (int i = 2; i >= 0; i--) begin
      if (a[hi[go[2*i+:2]]]) return hi[go[2*i+:2]];
      if (a[lo[go[2*i+:2]]]) return lo[go[2*i+:2]];
    end
    return 3'h0;
  endfunction

  // Count and report one comparison
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] y);
    total_checks++;
    if (x !== y) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", s, x, y);
    end
  endtask

  // Register write and read, one cycle each
  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    got = rdat;
  endtask

  // Enable or disable instruction pulse
  task automatic ins(input bit en);
    @(negedge clk);
    ei = en;
    di = !en;
    @(negedge clk);
    ei = 1'b0;
    di = 1'b0;
  endtask

  // Bounded wait for vector pulse or return pulse
  task automatic wt(input bit r);
    for (n = 0; n < 100 && (r ? ret : vv) !== 1'b1; n++) @(negedge clk);
    if (n == 100) begin
      bad_count++;
      results();
    end
  endtask

  // Counts, verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // --------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rdr(MASK_ADDR);
    chk("mask", 8'h00, got);
    rdr(PEND_ADDR);
    chk("pending", 8'h00, got);
    rdr(8'h10);
    chk("unmapped", 8'h00, got);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      rnd = nxt(rnd);
      q = (i == 0) ? 8'hff : rnd[15:8];
      wrr(PRIO_ADDR, rnd[7:0]);
      rdr(PRIO_ADDR);
      chk("priority", 8'h00, got);
      wrr(PEND_ADDR, q);
      rdr(PEND_ADDR);
      chk("pending", q & 8'h3f, got);
      wrr(MASK_ADDR, rnd[23:16] & 8'h7f);
      rdr(MASK_ADDR);
      chk("mask", rnd[23:16] & 8'h3f, got);
      wrr(PEND_ADDR, 8'h00);
      lreq = 6'h01 << i;
      @(negedge clk);
      lreq = 6'h00;
      rdr(PEND_ADDR);
      chk("pending", 8'h01 << i, got);
    end
    $display("test registers done");
    for (int k = 0; k < 24; k++) begin
      rnd = nxt(rnd);
      c = 3'(k % 6 + 1);
      p = {rnd[7:5], c[2:1], rnd[2:1], c[0]};
      q = (k == 0) ? 8'h3f : {2'b00, rnd[21:16] | 6'(1 << (k % 6))};
      m = (k == 0) ? 8'h3f : {2'b00, rnd[13:8]};
      if ((m & q) == 8'h00) m = 8'h3f;
      ad = {2'b00, rnd[25:24]};
      rdl = 4'h4 + {1'b0, rnd[28:26]};
      ins(1'b0);
      wrr(PRIO_ADDR, p);
      wrr(MASK_ADDR, m);
      wrr(PEND_ADDR, q);
      chk("request", 8'h00, {7'h00, irq});
      ins(1'b1);
      e = m & q;
      while (e != 8'h00) begin
        wt(1'b0);
        chk("level", {5'h00, win(p, e[5:0])}, {5'h00, vl});
        e[win(p, e[5:0])] = 1'b0;
        rdr(MASK_ADDR);
        chk("mask", m, got);
        wt(1'b1);
      end
      rdr(PEND_ADDR);
      chk("pending", q & ~m, got);
      rdr(MASK_ADDR);
      chk("mask", m | 8'h80, got);
    end
    $display("test priority done");
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rdr(MASK_ADDR);
    chk("mask", 8'h00, got);
    rdr(PEND_ADDR);
    chk("pending", 8'h00, got);
    wrr(MASK_ADDR, 8'h80);
    rdr(MASK_ADDR);
    chk("mask", 8'h80, got);
    ins(1'b0);
    rdr(MASK_ADDR);
    chk("mask", 8'h00, got);
    $display("test second reset done");
    results();
  end
endmodule
